/* File: core/bscc_chan.sv */
// bscc_chan: fixed-off-time chopper and dead-time bridge drive, one channel
`timescale 1ns/10ps
`default_nettype none
module bscc_chan #(
    parameter int DEAD_CYC = bscc_pkg::BSCC_DEAD_CYC
) (
    input wire logic clk_in,  // system clock
    input wire logic rst_in,  // async reset, active high
    bscc_chan_if.chan ch      // channel signals
);
    import bscc_pkg::*;

    localparam int DW = $clog2(DEAD_CYC + 1);
    localparam logic [DW-1:0] DEAD_LAST = DW'(DEAD_CYC);
    localparam logic [1:0] TICK_LAST = 2'(BSCC_CHOP_TICKS - 1);

    bscc_chop_t state_reg, state_next;
    bscc_bridge_t req, cur_reg;
    logic [1:0] tick_cnt_reg;
    logic [DW-1:0] dead_cnt_reg;
    logic [3:0] gate_reg;
    logic [3:0] req_gate;
    logic tick_last;

    // interval end and bridge request; brake while discharging
    assign tick_last = ch.tick && (tick_cnt_reg == TICK_LAST);
    assign req = !ch.en ? BSCC_BR_OFF :
        (state_reg == BSCC_CH_DISCH) ? BSCC_BR_BRAKE :
        ch.dir ? BSCC_BR_FWD : BSCC_BR_REV;
    assign req_gate = (req == BSCC_BR_FWD) ? BSCC_GATE_FWD :
        (req == BSCC_BR_REV) ? BSCC_GATE_REV :
        (req == BSCC_BR_BRAKE) ? BSCC_GATE_BRAKE : BSCC_GATE_OFF;
    assign ch.gate = gate_reg;
    assign ch.disch = (state_reg == BSCC_CH_DISCH);

    // chopper mode; a disabled bridge restarts in plain charge
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BSCC_CH_RUN: begin
                if (ch.over) state_next = BSCC_CH_DISCH;
            end
            BSCC_CH_DISCH: begin
                if (tick_last)
                    state_next = ch.over ? BSCC_CH_DISCH : BSCC_CH_BLANK;
            end
            BSCC_CH_BLANK: begin
                if (tick_last)
                    state_next = ch.over ? BSCC_CH_DISCH : BSCC_CH_RUN;
            end
            default: state_next = BSCC_CH_RUN;
        endcase
        if (!ch.en) state_next = BSCC_CH_RUN;
    end

    // mode register and oscillator tick count; wraps for a repeat interval
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= BSCC_CH_RUN;
            tick_cnt_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg) tick_cnt_reg <= 2'h0;
            else if (ch.tick) tick_cnt_reg <= tick_cnt_reg + 2'h1;
        end
    end

    // every change holds all gates off first; turning off is immediate
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cur_reg <= BSCC_BR_OFF;
            dead_cnt_reg <= '0;
            gate_reg <= BSCC_GATE_OFF;
        end else if (req == cur_reg && gate_reg == req_gate) begin
            // a request that returns to the current mode mid-gap keeps
            // counting, so the gates never stay parked off
            dead_cnt_reg <= '0;
        end else if (req == BSCC_BR_OFF || dead_cnt_reg == DEAD_LAST) begin
            cur_reg <= req;
            gate_reg <= req_gate;
            dead_cnt_reg <= '0;
        end else begin
            gate_reg <= BSCC_GATE_OFF;
            dead_cnt_reg <= dead_cnt_reg + DW'(1);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_leg_overlap: assert property (!(gate_reg[3] && gate_reg[2]) &&
        !(gate_reg[1] && gate_reg[0])) else $error("leg shoot-through");
    a_dead_gap: assert property ($fell(gate_reg[BSCC_G_T1_HI]) |->
        !gate_reg[BSCC_G_T1_LO] [*6]) else $error("dead time too short");
    a_dir_sense: assert property ((gate_reg == BSCC_GATE_FWD) |->
        $past(ch.dir)) else $error("forward drive against direction");
    a_brake_disch: assert property ((gate_reg == BSCC_GATE_BRAKE) |->
        $past(state_reg == BSCC_CH_DISCH)) else $error("brake outside chop");
    a_enter_disch: assert property (ch.en && state_reg == BSCC_CH_RUN &&
        ch.over |=> state_reg == BSCC_CH_DISCH) else $error("no discharge");
    a_blank_check: assert property (ch.en && state_reg == BSCC_CH_BLANK &&
        tick_last && ch.over |=> state_reg == BSCC_CH_DISCH)
        else $error("no discharge after blank");
    a_disch_recheck: assert property (ch.en && tick_last &&
        state_reg == BSCC_CH_DISCH |=> state_reg ==
        ($past(ch.over) ? BSCC_CH_DISCH : BSCC_CH_BLANK))
        else $error("wrong mode after discharge");
    a_charge_stay: assert property (ch.en && state_reg == BSCC_CH_RUN &&
        !ch.over |=> state_reg == BSCC_CH_RUN) else $error("charge left");
    a_disch_full: assert property (ch.en && state_reg == BSCC_CH_DISCH &&
        !tick_last |=> state_reg == BSCC_CH_DISCH) else $error("short discharge");
    c_brake: cover property (gate_reg == BSCC_GATE_BRAKE);
    c_disch_again: cover property (state_reg == BSCC_CH_DISCH && tick_last
        && ch.over);

endmodule : bscc_chan
`default_nettype wire

/* File: core/bscc_chan_if.sv */
// bscc_chan_if: signals between the top and one channel engine
`timescale 1ns/10ps
`default_nettype none
interface bscc_chan_if;
    logic en;          // bridge may conduct
    logic dir;         // high: term1 to term2
    logic over;        // sense voltage at or above reference
    logic tick;        // oscillator clock enable
    logic disch;       // chopper in discharge
    logic [3:0] gate;  // registered gate drives
    modport top (output en, dir, over, tick, input disch, gate);
    modport chan (input en, dir, over, tick, output disch, gate);
endinterface : bscc_chan_if
`default_nettype wire

/* File: core/bscc_pkg.sv */
// bscc_pkg: shared types and constants of the stepper chopper block
package bscc_pkg;

    // coil current level, encoded as {second select, first select}
    typedef enum logic [1:0] {
        BSCC_LVL_FULL = 2'h0,
        BSCC_LVL_THIRD = 2'h1,
        BSCC_LVL_TWO3 = 2'h2,
        BSCC_LVL_ZERO = 2'h3
    } bscc_level_t;

    // requested condition of one full bridge
    typedef enum logic [1:0] {
        BSCC_BR_OFF = 2'h0,
        BSCC_BR_FWD = 2'h1,
        BSCC_BR_BRAKE = 2'h3,
        BSCC_BR_REV = 2'h2
    } bscc_bridge_t;

    // chopper mode, usual path run -> discharge -> blank -> run
    typedef enum logic [1:0] {
        BSCC_CH_RUN = 2'h0,
        BSCC_CH_DISCH = 2'h1,
        BSCC_CH_BLANK = 2'h3
    } bscc_chop_t;

    // overcurrent guard
    typedef enum logic {BSCC_OC_WATCH = 1'h0, BSCC_OC_HOLD = 1'h1} bscc_oc_t;

    // gate vector: {term1 high, term1 low, term2 high, term2 low}
    localparam int BSCC_G_T1_HI = 3;
    localparam int BSCC_G_T1_LO = 2;
    localparam int BSCC_G_T2_HI = 1;
    localparam int BSCC_G_T2_LO = 0;
    localparam logic [3:0] BSCC_GATE_OFF = 4'h0;
    localparam logic [3:0] BSCC_GATE_FWD = 4'h9;
    localparam logic [3:0] BSCC_GATE_REV = 4'h6;
    localparam logic [3:0] BSCC_GATE_BRAKE = 4'h5;

    // timing at the 20 MHz system clock
    localparam int BSCC_CLK_NS = 50;
    localparam int BSCC_CLK_KHZ = 20000;
    localparam int BSCC_OSC_KHZ = 110;
    localparam int BSCC_OSC_DIV = BSCC_CLK_KHZ / BSCC_OSC_KHZ;
    localparam int BSCC_CHOP_TICKS = 4;
    localparam int BSCC_DEAD_NS = 300;
    localparam int BSCC_DEAD_CYC =
        (BSCC_DEAD_NS + BSCC_CLK_NS - 1) / BSCC_CLK_NS;
    localparam int BSCC_OC_FILT_US = 10;
    localparam int BSCC_OC_FILT_CYC =
        (BSCC_OC_FILT_US * 1000 + BSCC_CLK_NS - 1) / BSCC_CLK_NS;
    localparam int BSCC_OC_HOLD_US = 50;
    localparam int BSCC_OC_HOLD_CYC =
        (BSCC_OC_HOLD_US * 1000 + BSCC_CLK_NS - 1) / BSCC_CLK_NS;

endpackage : bscc_pkg

/* File: core/bscc_top.sv */
// bscc_top: dual-channel bipolar stepper chopper control, top level
`timescale 1ns/10ps
`default_nettype none
module bscc_top #(
    parameter int OSC_DIV = bscc_pkg::BSCC_OSC_DIV,
    parameter int DEAD_CYC = bscc_pkg::BSCC_DEAD_CYC,
    parameter int OC_FILT_CYC = bscc_pkg::BSCC_OC_FILT_CYC,
    parameter int OC_HOLD_CYC = bscc_pkg::BSCC_OC_HOLD_CYC
) (
    input wire logic clk_in,                 // system clock, 20 MHz
    input wire logic rst_in,                 // async reset, active high
    input wire logic standby_input_in,       // low: standby
    input wire logic dir_a_in,               // channel a direction
    input wire logic lvl_sel_lo_ch_a_in,     // channel a first select
    input wire logic lvl_sel_hi_ch_a_in,     // channel a second select
    input wire logic sense_voltage_a_in,     // a sense at reference
    input wire logic dir_b_in,               // channel b direction
    input wire logic lvl_sel_lo_ch_b_in,     // channel b first select
    input wire logic lvl_sel_hi_ch_b_in,     // channel b second select
    input wire logic sense_voltage_b_in,     // b sense at reference
    input wire logic thermal_trip_in,        // junction too hot
    input wire logic [7:0] overcurrent_trip_in, // per transistor
    output logic coil_a_term1_hi_out,        // a term1 upper gate
    output logic coil_a_term1_lo_out,        // a term1 lower gate
    output logic coil_a_term2_hi_out,        // a term2 upper gate
    output logic coil_a_term2_lo_out,        // a term2 lower gate
    output logic coil_b_term1_hi_out,        // b term1 upper gate
    output logic coil_b_term1_lo_out,        // b term1 lower gate
    output logic coil_b_term2_hi_out,        // b term2 upper gate
    output logic coil_b_term2_lo_out,        // b term2 lower gate
    output var bscc_pkg::bscc_level_t coil_a_level_out, // a ref scale
    output var bscc_pkg::bscc_level_t coil_b_level_out, // b ref scale
    output logic coil_a_disch_out,           // a in discharge
    output logic coil_b_disch_out,           // b in discharge
    output logic thermal_off_out,            // thermal shutdown active
    output logic overcurrent_off_out         // overcurrent hold active
);
    import bscc_pkg::*;

    localparam int OW = $clog2(OSC_DIV);
    localparam logic [OW-1:0] OSC_LAST = OW'(OSC_DIV - 1);
    localparam int CMAX = (OC_HOLD_CYC > OC_FILT_CYC) ?
        OC_HOLD_CYC : OC_FILT_CYC;
    localparam int CW = $clog2(CMAX + 1);
    localparam logic [CW-1:0] FILT_LAST = CW'(OC_FILT_CYC - 1);
    localparam logic [CW-1:0] HOLD_LAST = CW'(OC_HOLD_CYC - 1);
    localparam logic [CW-1:0] FILT_FULL = CW'(OC_FILT_CYC);

    // level decode, shared by both channels
    function automatic bscc_level_t lvl_decode(input logic lo,
                                               input logic hi);
        lvl_decode = bscc_level_t'({hi, lo});
    endfunction : lvl_decode

    bscc_chan_if ch [2] ();

    logic [OW-1:0] osc_cnt_reg;
    logic osc_tick_reg;
    logic osc_wrap;
    bscc_oc_t oc_state_reg, oc_state_next;
    logic [CW-1:0] oc_cnt_reg, oc_cnt_next;
    logic oc_any;
    logic run_ok;
    logic thermal_off_reg;
    logic oc_off_reg;
    logic [1:0] dir_v;
    logic [1:0] sense_v;
    logic [1:0] disch_reg;
    bscc_level_t lvl_v [2];
    bscc_level_t level_reg [2];

    // per-channel input grouping
    assign dir_v = {dir_b_in, dir_a_in};
    assign sense_v = {sense_voltage_b_in, sense_voltage_a_in};
    assign lvl_v[0] = lvl_decode(lvl_sel_lo_ch_a_in, lvl_sel_hi_ch_a_in);
    assign lvl_v[1] = lvl_decode(lvl_sel_lo_ch_b_in, lvl_sel_hi_ch_b_in);

    // bridges may conduct only when awake and no protection is active
    assign oc_any = |overcurrent_trip_in;
    assign run_ok = standby_input_in && !thermal_trip_in &&
        (oc_state_reg == BSCC_OC_WATCH);

    // triangular oscillator stand-in: one-cycle enable per period
    assign osc_wrap = (osc_cnt_reg == OSC_LAST);
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            osc_cnt_reg <= '0;
            osc_tick_reg <= 1'b0;
        end else begin
            osc_cnt_reg <= osc_wrap ? '0 : osc_cnt_reg + OW'(1);
            osc_tick_reg <= osc_wrap;
        end
    end

    // overcurrent guard: filter a persistent trip, then hold off
    always_comb begin
        oc_state_next = oc_state_reg;
        oc_cnt_next = oc_cnt_reg;
        case (oc_state_reg)
            BSCC_OC_WATCH: begin
                if (!oc_any) begin
                    oc_cnt_next = '0;
                end else if (oc_cnt_reg == FILT_LAST) begin
                    oc_state_next = BSCC_OC_HOLD;
                    oc_cnt_next = '0;
                end else begin
                    oc_cnt_next = oc_cnt_reg + CW'(1);
                end
            end
            BSCC_OC_HOLD: begin
                if (oc_cnt_reg == HOLD_LAST) begin
                    oc_state_next = BSCC_OC_WATCH;
                    oc_cnt_next = '0;
                end else begin
                    oc_cnt_next = oc_cnt_reg + CW'(1);
                end
            end
            default: begin
                oc_state_next = BSCC_OC_WATCH;
                oc_cnt_next = '0;
            end
        endcase
    end

    // a trip still present after the hold simply re-arms the filter
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            oc_state_reg <= BSCC_OC_WATCH;
            oc_cnt_reg <= '0;
        end else begin
            oc_state_reg <= oc_state_next;
            oc_cnt_reg <= oc_cnt_next;
        end
    end

    // channel engines; zero level or standby leaves the bridge off
    for (genvar gi = 0; gi < 2; gi++) begin : g_ch
        assign ch[gi].en = run_ok && (lvl_v[gi] != BSCC_LVL_ZERO);
        assign ch[gi].dir = dir_v[gi];
        assign ch[gi].over = sense_v[gi];
        assign ch[gi].tick = osc_tick_reg;
        bscc_chan #(
            .DEAD_CYC(DEAD_CYC)
        ) u_chan (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .ch(ch[gi])
        );
    end

    // status flops; level reads zero in standby so the ref is parked
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            level_reg[0] <= BSCC_LVL_ZERO;
            level_reg[1] <= BSCC_LVL_ZERO;
            disch_reg <= 2'h0;
            thermal_off_reg <= 1'b0;
            oc_off_reg <= 1'b0;
        end else begin
            level_reg[0] <= standby_input_in ? lvl_v[0] : BSCC_LVL_ZERO;
            level_reg[1] <= standby_input_in ? lvl_v[1] : BSCC_LVL_ZERO;
            disch_reg <= {ch[1].disch, ch[0].disch};
            thermal_off_reg <= thermal_trip_in;
            oc_off_reg <= (oc_state_next == BSCC_OC_HOLD);
        end
    end

    // gate outputs come straight from the channel gate flops
    assign coil_a_term1_hi_out = ch[0].gate[BSCC_G_T1_HI];
    assign coil_a_term1_lo_out = ch[0].gate[BSCC_G_T1_LO];
    assign coil_a_term2_hi_out = ch[0].gate[BSCC_G_T2_HI];
    assign coil_a_term2_lo_out = ch[0].gate[BSCC_G_T2_LO];
    assign coil_b_term1_hi_out = ch[1].gate[BSCC_G_T1_HI];
    assign coil_b_term1_lo_out = ch[1].gate[BSCC_G_T1_LO];
    assign coil_b_term2_hi_out = ch[1].gate[BSCC_G_T2_HI];
    assign coil_b_term2_lo_out = ch[1].gate[BSCC_G_T2_LO];
    assign coil_a_level_out = level_reg[0];
    assign coil_b_level_out = level_reg[1];
    assign coil_a_disch_out = disch_reg[0];
    assign coil_b_disch_out = disch_reg[1];
    assign thermal_off_out = thermal_off_reg;
    assign overcurrent_off_out = oc_off_reg;

    // checking helpers: trip streak and hold length, counted apart
    logic [CW-1:0] hlp_streak_reg;
    logic [CW-1:0] hlp_hold_reg;
    logic all_off;
    assign all_off = ~|{ch[1].gate, ch[0].gate};
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hlp_streak_reg <= '0;
            hlp_hold_reg <= '0;
        end else begin
            if (!oc_any) hlp_streak_reg <= '0;
            else if (hlp_streak_reg != FILT_FULL)
                hlp_streak_reg <= hlp_streak_reg + CW'(1);
            if (oc_state_reg == BSCC_OC_HOLD)
                hlp_hold_reg <= hlp_hold_reg + CW'(1);
            else
                hlp_hold_reg <= '0;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_level_third: assert property (standby_input_in &&
        lvl_sel_lo_ch_a_in && !lvl_sel_hi_ch_a_in |=>
        coil_a_level_out == BSCC_LVL_THIRD) else $error("level not third");
    a_level_two3: assert property (standby_input_in &&
        !lvl_sel_lo_ch_b_in && lvl_sel_hi_ch_b_in |=>
        coil_b_level_out == BSCC_LVL_TWO3) else $error("level not two3");
    a_zero_off: assert property (lvl_sel_lo_ch_b_in &&
        lvl_sel_hi_ch_b_in |=> ch[1].gate == BSCC_GATE_OFF)
        else $error("zero level still drives");
    a_thermal_off: assert property (thermal_trip_in |=> all_off &&
        thermal_off_out) else $error("thermal trip left gates on");
    a_thermal_back: assert property (($fell(thermal_trip_in) ##0
        (ch[0].en && !sense_voltage_a_in && $stable(dir_a_in)) [*8])
        |=> ch[0].gate != BSCC_GATE_OFF) else $error("no thermal recovery");
    a_oc_all_off: assert property (oc_state_reg == BSCC_OC_HOLD
        |=> all_off) else $error("overcurrent left gates on");
    a_oc_hold_len: assert property ($fell(oc_state_reg == BSCC_OC_HOLD)
        |-> hlp_hold_reg == OC_HOLD_CYC) else $error("wrong hold length");
    a_oc_filter: assert property ($rose(oc_state_reg == BSCC_OC_HOLD)
        |-> hlp_streak_reg >= OC_FILT_CYC) else $error("trip too early");
    a_standby_off: assert property (!standby_input_in |=> all_off &&
        coil_a_level_out == BSCC_LVL_ZERO) else $error("standby drives");
    c_thermal_recover: cover property ($fell(thermal_trip_in) ##[1:20]
        ch[0].gate != BSCC_GATE_OFF);
    c_oc_cycle: cover property ($fell(oc_state_reg == BSCC_OC_HOLD));

endmodule : bscc_top
`default_nettype wire

/* File: testbench/bscc_seq_model.sv */
// bscc_seq_model: step sequencer driving the standby, direction and level pins
`timescale 1ns/10ps
`default_nettype none
module bscc_seq_model (
    input wire logic clk_in,        // system clock
    input wire logic rst_in,        // async reset, active high
    input wire logic run_in,        // leave standby when high
    input wire logic step_in,       // advance one step: two table entries in full step, else one
    input wire logic rev_in,        // walk the table backwards
    input wire logic [1:0] mode_in, // 0 full, 1 half, 2 quarter step
    output logic standby_out,       // standby pin drive
    output logic [5:0] pins_out     // {dir, lo, hi} of a, then of b
);
    // half table; its even entries give the full-step order
    localparam logic [5:0] HALF_TBL [8] = '{6'h24, 6'h3c, 6'h04, 6'h03,
        6'h00, 6'h18, 6'h20, 6'h23};
    localparam logic [5:0] QUART_TBL [16] = '{6'h18, 6'h30, 6'h29, 6'h22,
        6'h27, 6'h26, 6'h2d, 6'h34, 6'h1c, 6'h14, 6'h0d, 6'h06, 6'h03,
        6'h02, 6'h09, 6'h10};
    logic [3:0] idx_reg;
    logic [3:0] idx_next;
    logic [3:0] stride;
    logic [5:0] entry;
    // table walk, reversed order turns the motor the other way
    assign stride = (mode_in == 2'h0) ? 4'h2 : 4'h1;
    assign idx_next = rev_in ? idx_reg - stride : idx_reg + stride;
    assign entry = (mode_in == 2'h2) ? QUART_TBL[idx_reg] :
        HALF_TBL[idx_reg[2:0]];
    // pins change with no off interval; the block adds the gap
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            idx_reg <= 4'h0;
        end else if (step_in) begin
            idx_reg <= idx_next;
        end
    end
    // power up in standby with every select high
    assign #1 pins_out = rst_in ? 6'h1b : entry;
    assign #1 standby_out = run_in & ~rst_in;
endmodule : bscc_seq_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// tb_top: self-checking bench for the stepper chopper control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    n_fail++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    import bscc_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic run = 1'b0, step = 1'b0, rev = 1'b0, sense_a = 1'b0;
    logic therm = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [7:0] oc = 8'h00;
    wire logic sb;
    wire logic [5:0] pins;
    wire logic [3:0] ga, gb;
    wire logic dis_a, dis_b, th_off, oc_off;
    bscc_level_t lva, lvb;
    int n_fail = 0;
    int total_checks = 0;
    int c;
    initial forever #25 clk_in = ~clk_in;
    // short counts keep the protection and chopper runs brief
    bscc_top #(.OSC_DIV(4), .DEAD_CYC(6), .OC_FILT_CYC(5),
        .OC_HOLD_CYC(10)) DUT (
        .clk_in(clk_in), .rst_in(rst_in), .standby_input_in(sb),
        .dir_a_in(pins[5]), .lvl_sel_lo_ch_a_in(pins[4]),
        .lvl_sel_hi_ch_a_in(pins[3]), .sense_voltage_a_in(sense_a),
        .dir_b_in(pins[2]), .lvl_sel_lo_ch_b_in(pins[1]),
        .lvl_sel_hi_ch_b_in(pins[0]), .sense_voltage_b_in(sense_a),
        .thermal_trip_in(therm), .overcurrent_trip_in(oc),
        .coil_a_term1_hi_out(ga[3]), .coil_a_term1_lo_out(ga[2]),
        .coil_a_term2_hi_out(ga[1]), .coil_a_term2_lo_out(ga[0]),
        .coil_b_term1_hi_out(gb[3]), .coil_b_term1_lo_out(gb[2]),
        .coil_b_term2_hi_out(gb[1]), .coil_b_term2_lo_out(gb[0]),
        .coil_a_level_out(lva), .coil_b_level_out(lvb),
        .coil_a_disch_out(dis_a), .coil_b_disch_out(dis_b),
        .thermal_off_out(th_off), .overcurrent_off_out(oc_off));
    bscc_seq_model seq (.clk_in(clk_in), .rst_in(rst_in), .run_in(run),
        .step_in(step), .rev_in(rev), .mode_in(mode), .standby_out(sb),
        .pins_out(pins));
    // inputs move 1 ns after the edge, never on it
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    function automatic logic [3:0] exp_g(input logic [2:0] p);
        return (p[1] & p[0]) ? BSCC_GATE_OFF :
            (p[2] ? BSCC_GATE_FWD : BSCC_GATE_REV);
    endfunction : exp_g
    task automatic count_dis(input int n);
        repeat (n) begin
            c += (dis_a === 1'b1);
            tick(1);
        end
    endtask : count_dis
    task automatic end_test(input string nm);
        $display("test %s finished", nm);
    endtask : end_test
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // one table step: level at once, gates after exactly six dead cycles
    task automatic do_step();
        logic [3:0] oa;
        logic [3:0] ob;
        oa = ga;
        ob = gb;
        step = 1'b1;
        tick(1);
        step = 1'b0;
        tick(1);
        `CHK("level_a", {pins[3], pins[4]}, lva)
        `CHK("level_b", {pins[0], pins[1]}, lvb)
        tick(5);
        if (exp_g(pins[5:3]) !== oa) `CHK("gap_a", BSCC_GATE_OFF, ga)
        if (exp_g(pins[2:0]) !== ob) `CHK("gap_b", BSCC_GATE_OFF, gb)
        tick(1);
        `CHK("drive_a", exp_g(pins[5:3]), ga)
        `CHK("drive_b", exp_g(pins[2:0]), gb)
    endtask : do_step
    initial begin
        #500000;
        n_fail++;
        print_verdict();
    end
    initial begin
        tick(6);
        `CHK("rst_gate_a", BSCC_GATE_OFF, ga)
        `CHK("rst_level_a", BSCC_LVL_ZERO, lva)
        rst_in = 1'b0;
        tick(10);
        `CHK("sb_gate_a", BSCC_GATE_OFF, ga)
        `CHK("sb_level_b", BSCC_LVL_ZERO, lvb)
        end_test("power_up");
        run = 1'b1;
        tick(10);
        for (int m = 0; m < 3; m++) begin
            mode = m[1:0];
            rev = (m == 1);
            tick(8);
            for (int s = 0; s < (m == 2 ? 19 : 4 << m); s++) do_step();
        end
        end_test("stepping");
        run = 1'b0;
        tick(2);
        `CHK("sb_run_a", BSCC_GATE_OFF, ga)
        `CHK("sb_run_b", BSCC_GATE_OFF, gb)
        `CHK("sb_run_lvl", BSCC_LVL_ZERO, lva)
        run = 1'b1;
        tick(10);
        `CHK("resume_a", exp_g(pins[5:3]), ga)
        end_test("standby");
        // a one-cycle trip must still buy a full discharge
        sense_a = 1'b1;
        tick(1);
        sense_a = 1'b0;
        tick(4);
        c = 0;
        count_dis(6);
        `CHK("brake_a", BSCC_GATE_BRAKE, ga)
        count_dis(5);
        `CHK("disch_len", 11, c)
        tick(6);
        `CHK("back_charge", 1'b0, dis_a)
        sense_a = 1'b1;
        tick(20);
        `CHK("blank_end", 1'b1, dis_a)
        c = 0;
        count_dis(40);
        `CHK("redisch", 40, c)
        `CHK("redisch_b", 1'b1, dis_b)
        sense_a = 1'b0;
        tick(60);
        `CHK("drive_back", exp_g(pins[5:3]), ga)
        c = 0;
        count_dis(30);
        `CHK("stay_charge", 0, c)
        end_test("chopper");
        therm = 1'b1;
        tick(2);
        `CHK("th_gate_a", BSCC_GATE_OFF, ga)
        `CHK("th_gate_b", BSCC_GATE_OFF, gb)
        `CHK("th_flag", 1'b1, th_off)
        therm = 1'b0;
        tick(10);
        `CHK("th_back", exp_g(pins[5:3]), ga)
        `CHK("th_clear", 1'b0, th_off)
        end_test("thermal");
        // every transistor alone: glitch ignored, long trip held off
        for (int k = 0; k < 8; k++) begin
            oc[k] = 1'b1;
            tick(4);
            oc = 8'h00;
            tick(3);
            `CHK("oc_glitch", 1'b0, oc_off)
            `CHK("oc_glitch_a", exp_g(pins[5:3]), ga)
            oc[k] = 1'b1;
            tick(5);
            oc = 8'h00;
            `CHK("oc_trip", 1'b1, oc_off)
            tick(1);
            `CHK("oc_gate_a", BSCC_GATE_OFF, ga)
            `CHK("oc_gate_b", BSCC_GATE_OFF, gb)
            c = 1;
            repeat (19) begin
                c += (oc_off === 1'b1);
                tick(1);
            end
            `CHK("oc_hold", 10, c)
            tick(10);
            `CHK("oc_back", exp_g(pins[5:3]), ga)
        end
        end_test("overcurrent");
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
